// ---- hw/estop_overtravel_supervisor.sv ----
// Emergency-stop and overtravel supervisor for a five-axis motion controller
`default_nettype none
module estop_overtravel_supervisor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Machine pins (1 = connected to +24V)
  input wire logic emergency_stop_in,
  input wire logic [estop_pkg::NUM_AXES-1:0] limit_minus_in,
  input wire logic [estop_pkg::NUM_AXES-1:0] limit_plus_in,
  input wire logic reset_key_in,
  // Configuration
  input wire logic estop_ignore,
  input wire logic limit_polarity,
  input wire logic overtravel_check_en,
  input wire logic axis4_limit_en,
  input wire logic axis5_limit_en,
  input wire logic [1:0] limit_mode_sel,
  input wire logic reset_key_en,
  // Controller state (same clock)
  input wire estop_pkg::op_mode_t op_mode,
  input wire logic [estop_pkg::NUM_AXES-1:0] axis_dir_minus,
  input wire logic [estop_pkg::NUM_AXES-1:0] motion_req,
  // Outputs
  output logic drive_enable,
  output logic emergency_alarm,
  output logic [estop_pkg::NUM_AXES-1:0] overtravel_plus_alarm,
  output logic [estop_pkg::NUM_AXES-1:0] overtravel_minus_alarm,
  output logic [estop_pkg::NUM_AXES-1:0] motion_allow,
  output logic system_reset_pulse,
  output logic cursor_return_pulse
);
  import estop_pkg::*;
  // Every pin passes a three-stage filter. Stop and limit causes latch their
  // alarms, and only a fresh, enabled reset-key press with every cause gone
  // clears them. A stop alarm drops the drive enable and all motion; an
  // overtravel alarm leaves motion only in jog and handwheel mode.
  // Limitation: the clear is global, so one live cause keeps every alarm set.

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic estop_s, reset_key_s;
  logic [NUM_AXES-1:0] lim_minus_s, lim_plus_s;

  pin_sync u_sync_estop (
    .core_clk(core_clk),
    .rstn(rstn),
    .pin_in(emergency_stop_in),
    .level_out(estop_s)
  );

  pin_sync u_sync_reset (
    .core_clk(core_clk),
    .rstn(rstn),
    .pin_in(reset_key_in),
    .level_out(reset_key_s)
  );

  // One synchroniser per limit pin, both ends
  genvar g;
  generate
    for (g = 0; g < NUM_AXES; g++) begin : g_lim
      pin_sync u_sync_minus (
        .core_clk(core_clk),
        .rstn(rstn),
        .pin_in(limit_minus_in[g]),
        .level_out(lim_minus_s[g])
      );
      pin_sync u_sync_plus (
        .core_clk(core_clk),
        .rstn(rstn),
        .pin_in(limit_plus_in[g]),
        .level_out(lim_plus_s[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Synchroniser fill guard
  logic [2:0] fill_q, fill_d;
  logic pins_valid;

  // The synchronisers leave reset reading 0, which looks like an open contact.
  // Pin causes are held off until the filter has seen the real level, so a
  // reset cannot latch a false stop or limit alarm; the price is a few blind
  // cycles right after reset.
  always_comb begin
    pins_valid = (fill_q == 3'(SYNC_STAGES + 1));
    fill_d = pins_valid ? fill_q : fill_q + 3'h1;
  end

  // Counter parks at its end value until the next reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fill_q <= 3'h0;
    end else begin
      fill_q <= fill_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Limit decoding
  logic [NUM_AXES-1:0] axis_en;
  logic [NUM_AXES-1:0] act_minus, act_plus;
  logic [NUM_AXES-1:0] hit_minus, hit_plus;
  logic mode_sep, mode_comb;
  logic estop_hit, reset_press;

  // Per-axis enables, polarity and mode decode
  always_comb begin
    mode_sep = (limit_mode_sel == LIM_MODE_SEPARATE);
    mode_comb = (limit_mode_sel == LIM_MODE_COMBINED);
    axis_en = '0;
    axis_en[2:0] = {3{overtravel_check_en}};
    axis_en[AXIS4_IDX] = axis4_limit_en;
    axis_en[AXIS5_IDX] = axis5_limit_en;
    // Polarity 1 trips on an open contact, 0 on a closed one
    act_minus = limit_polarity ? ~lim_minus_s : lim_minus_s;
    act_plus = limit_polarity ? ~lim_plus_s : lim_plus_s;
    // Open contact on the stop loop trips the alarm unless masked
    estop_hit = ~estop_s & ~estop_ignore & pins_valid;
  end

  // Per-axis end decode, one copy of the same logic for every axis
  for (g = 0; g < NUM_AXES; g++) begin : g_hit
    logic live, minus_end, plus_end;
    always_comb begin
      live = pins_valid & axis_en[g];
      minus_end = 1'b0;
      plus_end = 1'b0;
      if (live && mode_sep) begin
        minus_end = act_minus[g];
        plus_end = act_plus[g];
      end else if (live && mode_comb) begin
        // Single switch sits on the plus pin; end follows travel direction
        minus_end = act_plus[g] & axis_dir_minus[g];
        plus_end = act_plus[g] & ~axis_dir_minus[g];
      end
    end
    assign hit_minus[g] = minus_end;
    assign hit_plus[g] = plus_end;
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset key edge detection
  logic key_prev_q, key_prev_d;

  // Only a fresh press counts; a held key cannot re-clear new alarms
  always_comb begin
    key_prev_d = reset_key_s;
    reset_press = reset_key_s & ~key_prev_q & reset_key_en;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      key_prev_q <= 1'b0;
    end else begin
      key_prev_q <= key_prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarm latches and supervisor state
  sup_state_t state_q, state_d;
  logic estop_alm_q, estop_alm_d;
  logic [NUM_AXES-1:0] ot_plus_q, ot_plus_d, ot_minus_q, ot_minus_d;
  logic sys_rst_q, sys_rst_d, cur_ret_q, cur_ret_d;
  logic clear_ok;
  logic alarm_pending;

  // Set wins over clear; a clear needs every cause gone first
  always_comb begin
    clear_ok = reset_press && !estop_hit && ((hit_plus | hit_minus) == '0);
    estop_alm_d = estop_alm_q;
    ot_plus_d = ot_plus_q;
    ot_minus_d = ot_minus_q;
    if (clear_ok) begin
      estop_alm_d = 1'b0;
      ot_plus_d = '0;
      ot_minus_d = '0;
    end
    if (estop_hit) begin
      estop_alm_d = 1'b1;
    end
    ot_plus_d = ot_plus_d | hit_plus;
    ot_minus_d = ot_minus_d | hit_minus;
    alarm_pending = estop_alm_d || ((ot_plus_d | ot_minus_d) != '0);
    // Reset-key functions, gated by the enable
    sys_rst_d = reset_press;
    cur_ret_d = reset_press && (op_mode == MODE_AUTO);
  end

  // Supervisor state: notes whether a clear is still owed
  always_comb begin
    case (state_q)
      ST_NORMAL: begin
        state_d = alarm_pending ? ST_ALARM : ST_NORMAL;
      end
      ST_ALARM: begin
        state_d = clear_ok ? ST_CLEAR : ST_ALARM;
      end
      ST_CLEAR: begin
        state_d = alarm_pending ? ST_ALARM : ST_NORMAL;
      end
      default: begin
        state_d = ST_ALARM;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_NORMAL;
    end else begin
      state_q <= state_d;
    end
  end

  // Latches and pulses; reset leaves every alarm clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      estop_alm_q <= 1'b0;
      ot_plus_q <= '0;
      ot_minus_q <= '0;
      sys_rst_q <= 1'b0;
      cur_ret_q <= 1'b0;
    end else begin
      estop_alm_q <= estop_alm_d;
      ot_plus_q <= ot_plus_d;
      ot_minus_q <= ot_minus_d;
      sys_rst_q <= sys_rst_d;
      cur_ret_q <= cur_ret_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Motion permission and drive enable
  logic manual_mode;
  logic any_ot;
  logic drv_en_q, drv_en_d;
  logic [NUM_AXES-1:0] allow_q, allow_d;

  // Overtravel leaves only jog and handwheel moves; estop stops everything
  always_comb begin
    manual_mode = (op_mode == MODE_JOG) || (op_mode == MODE_HANDWHEEL);
    // Next-value view, so the gate closes on the same edge as the alarm
    any_ot = (ot_plus_d | ot_minus_d) != '0;
    drv_en_d = ~estop_alm_d;
  end

  // Per-axis motion gate; no direction check, the operator backs off by hand
  for (g = 0; g < NUM_AXES; g++) begin : g_allow
    assign allow_d[g] = motion_req[g] & ~estop_alm_d & (~any_ot | manual_mode);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      drv_en_q <= 1'b0;
      allow_q <= '0;
    end else begin
      drv_en_q <= drv_en_d;
      allow_q <= allow_d;
    end
  end

  // Outputs all from flip-flops
  assign drive_enable = drv_en_q;
  assign emergency_alarm = estop_alm_q;
  assign overtravel_plus_alarm = ot_plus_q;
  assign overtravel_minus_alarm = ot_minus_q;
  assign motion_allow = allow_q;
  assign system_reset_pulse = sys_rst_q;
  assign cursor_return_pulse = cur_ret_q;
endmodule : estop_overtravel_supervisor
`default_nettype wire

// ---- hw/estop_pkg.sv ----
// Package of constants and types for the emergency-stop and overtravel supervisor
// Functional notes
// - Act on emergency-stop input when estop_ignore is 0; ignore it when 1.
// - limit_polarity 1: alarm when input opens; 0: alarm when input connects.
// - Check linear-axis overtravel inputs only when overtravel_check_en is 1.
// - Fourth and fifth axis limits count only when their enable is 1.
// - Limit mode 10 separate, 01 combined, 00 or 11 disables limits.
// - Combined mode: one input per axis, end chosen by motion direction.
// - During overtravel only jog or handwheel motion; clear on reset once inactive.
// - Emergency-stop input losing +24V raises the emergency alarm.
// - Emergency alarm drops drive_enable, stopping axis pulse output.
// - Reset key works (system reset, cursor return) only when reset_key_en is 1.
// - Reset in automatic mode resets the system and returns program pointer.
// - Separate mode: each axis has distinct minus and plus inputs, monitored apart.
`default_nettype none
package estop_pkg;
  // Axis count and indices (X, Y, Z, 4th, 5th)
  localparam int unsigned NUM_AXES = 5;
  localparam int unsigned AXIS4_IDX = 3;
  localparam int unsigned AXIS5_IDX = 4;
  // Limit mode field encodings
  localparam logic [1:0] LIM_MODE_SEPARATE = 2'h2;
  localparam logic [1:0] LIM_MODE_COMBINED = 2'h1;
  // Synchroniser depth for pin inputs
  localparam int unsigned SYNC_STAGES = 3;
  // Operating modes presented by the controller
  typedef enum logic [2:0] {
    MODE_AUTO = 3'b000,
    MODE_MDI = 3'b001,
    MODE_JOG = 3'b010,
    MODE_HANDWHEEL = 3'b011,
    MODE_OTHER = 3'b100
  } op_mode_t;
  // Alarm supervisor states
  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_ALARM = 2'b01,
    ST_CLEAR = 2'b10
  } sup_state_t;
endpackage : estop_pkg
`default_nettype wire

// ---- hw/pin_sync.sv ----
// Three-stage synchroniser with agreement filter for asynchronous pins
`default_nettype none
module pin_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Pin and synchronised level
  input wire logic pin_in,
  output logic level_out
);
  logic s1_q, s2_q, s3_q, lvl_q;
  logic s1_d, s2_d, s3_d, lvl_d;

  // Next values: level follows once stages two and three agree
  always_comb begin
    s1_d = pin_in;
    s2_d = s1_q;
    s3_d = s2_q;
    lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
  end

  // Registers; reset to 0 (open contact)
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      lvl_q <= lvl_d;
    end
  end

  assign level_out = lvl_q;
endmodule : pin_sync
`default_nettype wire

// ---- bench/estop_monitor.sv ----
// Port checker for the stop and overtravel supervisor
`default_nettype none
module estop_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Inputs
  input wire logic emergency_stop_in,
  input wire logic estop_ignore,
  input wire logic reset_key_en,
  input wire estop_pkg::op_mode_t op_mode,
  // Outputs
  input wire logic drive_enable,
  input wire logic emergency_alarm,
  input wire logic [estop_pkg::NUM_AXES-1:0] overtravel_plus_alarm,
  input wire logic [estop_pkg::NUM_AXES-1:0] overtravel_minus_alarm,
  input wire logic [estop_pkg::NUM_AXES-1:0] motion_allow,
  input wire logic system_reset_pulse,
  input wire logic cursor_return_pulse
);
  import estop_pkg::*;
  logic ot;
  // Any overtravel alarm at all
  assign ot = |{overtravel_plus_alarm, overtravel_minus_alarm};
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  a_estop_raise: assert property ((!emergency_stop_in && !estop_ignore) [*6] |=> emergency_alarm)
    else $error("stop alarm missing");
  a_drive_off: assert property (emergency_alarm |-> !drive_enable && motion_allow == '0)
    else $error("drives left on");
  a_estop_hold: assert property ($fell(emergency_alarm) |-> system_reset_pulse)
    else $error("stop alarm dropped alone");
  a_ot_hold: assert property ($fell(ot) |-> system_reset_pulse)
    else $error("overtravel dropped alone");
  a_pulse_once: assert property (system_reset_pulse |=> !system_reset_pulse)
    else $error("reset pulse too long");
  a_reset_gate: assert property (system_reset_pulse |-> $past(reset_key_en))
    else $error("reset while disabled");
  a_cursor_auto: assert property (cursor_return_pulse |-> system_reset_pulse
    && $past(op_mode) == MODE_AUTO)
    else $error("cursor return outside auto");
  a_jog_only: assert property (ot && |motion_allow
    |-> $past(op_mode) inside {MODE_JOG, MODE_HANDWHEEL})
    else $error("motion during overtravel");
  // Main scenarios
  cover property ($rose(emergency_alarm));
  cover property ($rose(ot));
  cover property (cursor_return_pulse);
endmodule : estop_monitor
bind estop_overtravel_supervisor estop_monitor mon (.*);
`default_nettype wire

// ---- bench/machine_model.sv ----
// Machine side: stop button and travel switches, 1 = +24V on the pin
`default_nettype none
module machine_model (
  // Actuation
  input wire logic stop_pressed,
  input wire logic [4:0] hit_plus,
  input wire logic [4:0] hit_minus,
  input wire logic combined,
  input wire logic limit_polarity,
  // Pins
  output logic emergency_stop_in,
  output logic [4:0] limit_plus_in,
  output logic [4:0] limit_minus_in
);
  logic [4:0] p;
  logic [4:0] n;
  // Button breaks the +24V loop
  assign emergency_stop_in = !stop_pressed;
  // Combined wiring puts both ends on one switch, the minus pin idles
  assign p = combined ? (hit_plus | hit_minus) : hit_plus;
  assign n = combined ? 5'h0 : hit_minus;
  // Opening contacts drop the pin, closing ones raise it
  assign limit_plus_in = limit_polarity ? ~p : p;
  assign limit_minus_in = limit_polarity ? ~n : n;
endmodule : machine_model
`default_nettype wire

// ---- bench/estop_overtravel_supervisor_tb.sv ----
// Self-checking bench for the stop and overtravel supervisor
`default_nettype none
module estop_overtravel_supervisor_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import estop_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic emergency_stop_in, reset_key_in, estop_ignore, limit_polarity, overtravel_check_en;
  logic axis4_limit_en, axis5_limit_en, reset_key_en, stop_pressed, combined, live, side;
  logic drive_enable, emergency_alarm, system_reset_pulse, cursor_return_pulse;
  logic [1:0] limit_mode_sel;
  logic [4:0] limit_minus_in, limit_plus_in, axis_dir_minus, motion_req, hit_plus, hit_minus;
  logic [4:0] overtravel_plus_alarm, overtravel_minus_alarm, motion_allow, xpl, xmi, xal;
  logic [10:0] alarms;
  op_mode_t op_mode;
  logic [31:0] r = 32'hfa95;
  logic [10:0] q[$];
  int err_total, total_checks, np, nc, xp, xc;
  event obs;
  assign combined = (limit_mode_sel == 2'h1);
  assign alarms = {emergency_alarm, overtravel_plus_alarm, overtravel_minus_alarm};
  machine_model sw (.*);
  estop_overtravel_supervisor dut (.*);
  always #2.5 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic settle();
    repeat (10) @(negedge core_clk);
  endtask : settle
  // Note the expected alarms, the watcher compares them
  task automatic note(input logic [10:0] e);
    q.push_back(e);
    ->obs;
  endtask : note
  task automatic press();
    xp += int'(reset_key_en);
    xc += int'(reset_key_en && op_mode == MODE_AUTO);
    reset_key_in = 1'b1;
    settle();
    reset_key_in = 1'b0;
    settle();
  endtask : press
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  // Watcher: outputs are settled at the falling edge
  always @obs check(16'(alarms), 16'(q.pop_front()));
  // Pulses counted at the falling edge, where they stand still
  always @(negedge core_clk) begin
    np += int'(system_reset_pulse);
    nc += int'(cursor_return_pulse);
  end
  // Watchdog, about eight times the expected run
  initial begin
    #100us;
    err_total++;
    report_and_stop();
  end
  initial begin
    {reset_key_in, stop_pressed, hit_plus, hit_minus, motion_req, axis_dir_minus} = '0;
    {estop_ignore, limit_polarity, overtravel_check_en, axis4_limit_en} = '1;
    {axis5_limit_en, reset_key_en} = '1;
    limit_mode_sel = 2'h2;
    op_mode = MODE_AUTO;
    repeat (6) @(negedge core_clk);
    rstn = 1'b1;
    settle();
    stop_pressed = 1'b1;
    settle();
    note(11'h0);
    estop_ignore = 1'b0;
    settle();
    note(11'h400);
    check(16'(drive_enable), 16'h0);
    stop_pressed = 1'b0;
    settle();
    note(11'h400);
    press();
    note(11'h0);
    check(16'(drive_enable), 16'h1);
    // Polarity flips make the idle pins glitch, so clear after each
    for (int p = 0; p < 2; p++) begin
      limit_polarity = 1'(p);
      settle();
      press();
      note(11'h0);
      for (int m = 0; m < 4; m++) begin
        for (int a = 0; a < 5; a++) begin
          r = lfsr(lfsr(lfsr(r)));
          limit_mode_sel = 2'(m);
          {overtravel_check_en, axis4_limit_en, axis5_limit_en} = r[3:1];
          axis_dir_minus = r[8:4];
          motion_req = r[13:9];
          op_mode = op_mode_t'({1'b0, r[15:14]});
          hit_minus = r[16] ? 5'(1 << a) : 5'h0;
          hit_plus = r[16] ? 5'h0 : 5'(1 << a);
          live = (a < 3) ? overtravel_check_en : (a == 3) ? axis4_limit_en : axis5_limit_en;
          live = live && (m == 1 || m == 2);
          side = (m == 1) ? axis_dir_minus[a] : r[16];
          xpl = (live && !side) ? 5'(1 << a) : 5'h0;
          xmi = (live && side) ? 5'(1 << a) : 5'h0;
          settle();
          note({1'b0, xpl, xmi});
          xal = ((xpl | xmi) != 5'h0 && op_mode < MODE_JOG) ? 5'h0 : motion_req;
          check(16'(motion_allow), 16'(xal));
          {hit_plus, hit_minus} = '0;
          reset_key_en = r[17];
          settle();
          press();
          note(r[17] ? 11'h0 : {1'b0, xpl, xmi});
          reset_key_en = 1'b1;
          press();
          note(11'h0);
        end
      end
    end
    check(16'(np), 16'(xp));
    check(16'(nc), 16'(xc));
    report_and_stop();
  end
endmodule : estop_overtravel_supervisor_tb
`default_nettype wire
